// ---- pkg/fpsc_chan_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fpsc_chan_if;
    import fpsc_pkg::*;
    logic [TEMP_W-1:0] temp;
    logic [BYTE_W-1:0] otLimit;
    logic [RATE_W-1:0] rate;
    logic [DUTY_W-1:0] duty;
    logic              flip;
    logic              otActive;
    logic              pwm;

    modport ctl    (output temp, output otLimit, output rate, output duty, output flip,
                    input otActive, input pwm);
    modport pwmGen (input rate, input duty, input flip, output pwm);
    modport otMon  (input temp, input otLimit, output otActive);
endinterface
`default_nettype wire

// ---- pkg/fpsc_pkg.sv ----
`default_nettype none
package fpsc_pkg;
    localparam int NUM_CH   = 3;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int STRB_W   = 4;
    localparam int BYTE_W   = 8;
    localparam int WORD_SHIFT = 2;

    // Span/rate register indices; byte address is index times four
    localparam logic [7:0] IDX_REMOTE1 = 8'h5F;
    localparam logic [7:0] IDX_LOCAL   = 8'h60;
    localparam logic [7:0] IDX_REMOTE2 = 8'h61;
    localparam logic [7:0] SPAN_IDX [NUM_CH] = '{IDX_REMOTE1, IDX_LOCAL, IDX_REMOTE2};

    localparam logic [ADDR_W-1:0] ADDR_LIM_BASE = 12'h190;
    localparam logic [ADDR_W-1:0] ADDR_CTRL     = 12'h1A0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h1A4;
    localparam logic [ADDR_W-1:0] ADDR_MASK     = 12'h1A8;

    // Span/rate register layout
    localparam logic [7:0] SPAN_RESET = 8'hC4;
    localparam int RATE_LSB  = 0;
    localparam int RATE_W    = 3;
    localparam int DRIVE_BIT = 3;
    localparam int SLOPE_LSB = 4;
    localparam int SLOPE_W   = 4;

    // Control register layout
    localparam int CTRL_W           = 5;
    localparam int CTRL_LOCK_BIT    = 0;
    localparam int CTRL_PINFUNC_BIT = 1;
    localparam int CTRL_FLIP_LSB    = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h02;

    // Limit register layout: low byte start temperature, high byte overtemp limit
    localparam int LIM_W        = 16;
    localparam int TMIN_LSB     = 0;
    localparam int OTLIM_LSB    = 8;
    localparam logic [LIM_W-1:0] LIM_RESET = 16'h643C;

    // Status and mask layout
    localparam int NUM_EV     = 4;
    localparam int EV_PIN_BIT = 3;

    localparam int TEMP_FRAC = 2;
    localparam int TEMP_W    = BYTE_W + TEMP_FRAC;
    localparam int DUTY_W    = 8;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
    localparam int STEP_W    = 16;
    localparam int MON_W     = 24;

    localparam longint CLK_HZ_DEF       = 25_000_000;
    localparam longint MON_CYCLE_US_DEF = 100_000;
    localparam longint US_PER_S         = 1_000_000;

    // PWM rates in hundredths of a hertz, one period has PWM_STEPS steps
    localparam longint CHZ_PER_HZ = 100;
    localparam longint PWM_STEPS  = 256;
    localparam longint RATE_CHZ [8] = '{1100, 1470, 2210, 2940, 3530, 4410, 5880, 8820};

    // Duty per quarter degree, scaled by 2^RECIP_FRAC; spans held in twelfths of a degree
    localparam int RECIP_W    = 13;
    localparam int RECIP_FRAC = 8;
    localparam int DUTY_SCALE = 255 * 256 * 12 / 4;
    localparam logic [RECIP_W-1:0] SLOPE_RECIP [16] = '{
        13'(DUTY_SCALE / 24),  13'(DUTY_SCALE / 30),  13'(DUTY_SCALE / 40),
        13'(DUTY_SCALE / 48),  13'(DUTY_SCALE / 60),  13'(DUTY_SCALE / 80),
        13'(DUTY_SCALE / 96),  13'(DUTY_SCALE / 120), 13'(DUTY_SCALE / 160),
        13'(DUTY_SCALE / 192), 13'(DUTY_SCALE / 240), 13'(DUTY_SCALE / 320),
        13'(DUTY_SCALE / 384), 13'(DUTY_SCALE / 480), 13'(DUTY_SCALE / 640),
        13'(DUTY_SCALE / 960)};

    function automatic logic [ADDR_W-1:0] spanAddr(input int ch);
        return ADDR_W'(SPAN_IDX[ch]) << WORD_SHIFT;
    endfunction

    function automatic logic [ADDR_W-1:0] limAddr(input int ch);
        return ADDR_LIM_BASE + (ADDR_W'(ch) << WORD_SHIFT);
    endfunction

    function automatic logic [DATA_W-1:0] wrMerge(input logic [DATA_W-1:0] old,
                                                  input logic [DATA_W-1:0] wd,
                                                  input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < STRB_W; b++) begin
            if (strb[b]) begin
                res[b*BYTE_W +: BYTE_W] = wd[b*BYTE_W +: BYTE_W];
            end
        end
        return res;
    endfunction

    function automatic logic [STEP_W-1:0] stepFor(input longint clkHz, input int code);
        longint n;
        n = (clkHz * CHZ_PER_HZ) / (RATE_CHZ[code] * PWM_STEPS);
        if (n < 1) begin
            n = 1;
        end
        return STEP_W'(n);
    endfunction

    function automatic logic [DUTY_W-1:0] dutyCalc(input logic [TEMP_W-1:0] temp,
                                                   input logic [BYTE_W-1:0] tmin,
                                                   input logic [SLOPE_W-1:0] slope);
        logic [TEMP_W-1:0]           base;
        logic [TEMP_W-1:0]           delta;
        logic [TEMP_W+RECIP_W-1:0]   prod;
        logic [TEMP_W+RECIP_W-RECIP_FRAC-1:0] scaled;
        base   = {tmin, {TEMP_FRAC{1'b0}}};
        delta  = (temp > base) ? temp - base : '0;
        prod   = (TEMP_W+RECIP_W)'(delta) * (TEMP_W+RECIP_W)'(SLOPE_RECIP[slope]);
        scaled = prod[TEMP_W+RECIP_W-1:RECIP_FRAC];
        return (scaled > DUTY_FULL) ? DUTY_FULL : scaled[DUTY_W-1:0];
    endfunction
endpackage
`default_nettype wire

// ---- src/fpsc_ot_mon.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpsc_ot_mon #(
    parameter logic [fpsc_pkg::MON_W-1:0] MON_CYCLES = 24'h00_0001
) (
    input wire logic          clk,
    input wire logic          rst,
    fpsc_chan_if.otMon        ch
);
    import fpsc_pkg::*;

    logic             active_r;
    logic [MON_W-1:0] hold_r;

    wire [TEMP_W-1:0] limQ  = {ch.otLimit, {TEMP_FRAC{1'b0}}};
    // One quarter degree above the limit is the first code strictly greater
    wire              above = ch.temp > limQ;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            hold_r   <= '0;
        end else if (!active_r) begin
            if (above) begin
                active_r <= 1'b1;
                hold_r   <= MON_CYCLES - MON_W'(1);
            end
        end else if (hold_r != '0) begin
            hold_r <= hold_r - MON_W'(1);
        end else if (!above) begin
            active_r <= 1'b0;
        end
    end

    assign ch.otActive = active_r;
endmodule
`default_nettype wire

// ---- src/fpsc_pwm_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpsc_pwm_gen #(
    parameter longint CLK_HZ = fpsc_pkg::CLK_HZ_DEF
) (
    input wire logic          clk,
    input wire logic          rst,
    fpsc_chan_if.pwmGen       ch
);
    import fpsc_pkg::*;

    logic [STEP_W-1:0] stepTab [8];
    logic [STEP_W-1:0] preCnt_r;
    logic [DUTY_W-1:0] phase_r;
    logic              out_r;

    // Table folds to constants; only the select is hardware
    for (genvar k = 0; k < 8; k++) begin : g_rate
        assign stepTab[k] = stepFor(CLK_HZ, k);
    end

    wire [STEP_W-1:0] stepLen  = stepTab[ch.rate];
    wire              stepTick = (preCnt_r >= stepLen - STEP_W'(1));
    // Full duty is a steady level, not a one-step gap
    wire              level    = (ch.duty == DUTY_FULL) | (phase_r < ch.duty);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            preCnt_r <= '0;
            phase_r  <= '0;
            out_r    <= 1'b0;
        end else begin
            preCnt_r <= stepTick ? '0 : preCnt_r + STEP_W'(1);
            if (stepTick) begin
                phase_r <= phase_r + DUTY_W'(1);
            end
            out_r <= level ^ ch.flip;
        end
    end

    assign ch.pwm = out_r;
endmodule
`default_nettype wire

// ---- src/fpsc_top.sv ----
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module fpsc_top #(
    parameter longint CLK_HZ       = fpsc_pkg::CLK_HZ_DEF,
    parameter longint MON_CYCLE_US = fpsc_pkg::MON_CYCLE_US_DEF
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [fpsc_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [fpsc_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [fpsc_pkg::STRB_W-1:0]   pstrb,
    output logic      [fpsc_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [fpsc_pkg::TEMP_W-1:0]   tempRemote1,
    input  wire logic [fpsc_pkg::TEMP_W-1:0]   tempLocal,
    input  wire logic [fpsc_pkg::TEMP_W-1:0]   tempRemote2,
    input  wire logic                          overtempPinIn,
    output logic                               overtempPinOut,
    output logic                               overtempPinOe,
    output logic                               pwmOut1,
    output logic                               pwmOut2,
    output logic                               pwmOut3,
    output logic                               irq
);
    import fpsc_pkg::*;

    localparam longint MON_RAW = (CLK_HZ * MON_CYCLE_US) / US_PER_S;
    localparam logic [MON_W-1:0] MON_CYCLES = (MON_RAW < 1) ? MON_W'(1) : MON_W'(MON_RAW);

    // Register state
    logic [BYTE_W-1:0] spanCfg_r  [NUM_CH];
    logic [BYTE_W-1:0] spanCfg_nxt[NUM_CH];
    logic [LIM_W-1:0]  lim_r      [NUM_CH];
    logic [LIM_W-1:0]  lim_nxt    [NUM_CH];
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [NUM_EV-1:0] status_r;
    logic [NUM_EV-1:0] status_nxt;
    logic [NUM_EV-1:0] mask_r;
    logic [NUM_EV-1:0] mask_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [NUM_CH-1:0] otPrev_r;
    logic              pinPrev_r;
    logic              pinOe_r;

    fpsc_chan_if chIf [NUM_CH] ();

    logic [TEMP_W-1:0] tempArr  [NUM_CH];
    logic [NUM_CH-1:0] otActive;
    logic [NUM_CH-1:0] pwmRaw;
    logic [NUM_CH-1:0] driveEn;
    logic [NUM_CH-1:0] selSpan;
    logic [NUM_CH-1:0] selLim;
    logic [DATA_W-1:0] rdAcc    [NUM_CH+1];

    assign tempArr[0] = tempRemote1;
    assign tempArr[1] = tempLocal;
    assign tempArr[2] = tempRemote2;

    // Bus decode
    wire setupRd  = psel & ~penable & ~pwrite;
    wire access   = psel & penable;
    wire wrEn     = access & pwrite;
    wire selCtrl  = (paddr == ADDR_CTRL);
    wire selStat  = (paddr == ADDR_STATUS);
    wire selMask  = (paddr == ADDR_MASK);
    wire hit      = (|selSpan) | (|selLim) | selCtrl | selStat | selMask;
    wire locked   = ctrl_r[CTRL_LOCK_BIT];
    wire pinFunc  = ctrl_r[CTRL_PINFUNC_BIT];

    wire [DATA_W-1:0] ctrlMerged = wrMerge(DATA_W'(ctrl_r), pwdata, pstrb);
    wire [DATA_W-1:0] maskMerged = wrMerge(DATA_W'(mask_r), pwdata, pstrb);
    wire [DATA_W-1:0] w1cWord    = wrMerge('0, pwdata, pstrb);

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        wire [DATA_W-1:0] spanMerged = wrMerge(DATA_W'(spanCfg_r[g]), pwdata, pstrb);
        wire [DATA_W-1:0] limMerged  = wrMerge(DATA_W'(lim_r[g]), pwdata, pstrb);

        assign selSpan[g] = (paddr == spanAddr(g));
        assign selLim[g]  = (paddr == limAddr(g));

        // A locked span write falls through as if it were never there; limit writes still land
        assign spanCfg_nxt[g] = (wrEn & selSpan[g] & ~locked)
                              ? spanMerged[BYTE_W-1:0] : spanCfg_r[g];
        assign lim_nxt[g]     = (wrEn & selLim[g]) ? limMerged[LIM_W-1:0] : lim_r[g];

        assign rdAcc[g+1] = rdAcc[g]
                          | (selSpan[g] ? DATA_W'(spanCfg_r[g]) : '0)
                          | (selLim[g]  ? DATA_W'(lim_r[g])     : '0);

        assign driveEn[g] = spanCfg_r[g][DRIVE_BIT];
        assign chIf[g].temp    = tempArr[g];
        assign chIf[g].otLimit = lim_r[g][OTLIM_LSB +: BYTE_W];
        assign chIf[g].rate    = spanCfg_r[g][RATE_LSB +: RATE_W];
        assign chIf[g].duty    = dutyCalc(tempArr[g],
                                          lim_r[g][TMIN_LSB +: BYTE_W],
                                          spanCfg_r[g][SLOPE_LSB +: SLOPE_W]);
        assign chIf[g].flip    = ctrl_r[CTRL_FLIP_LSB + g];
        assign otActive[g]     = chIf[g].otActive;
        assign pwmRaw[g]       = chIf[g].pwm;

        fpsc_pwm_gen #(
            .CLK_HZ     (CLK_HZ)
        ) u_pwm (
            .clk        (clk),
            .rst        (rst),
            .ch         (chIf[g])
        );

        fpsc_ot_mon #(
            .MON_CYCLES (MON_CYCLES)
        ) u_ot (
            .clk        (clk),
            .rst        (rst),
            .ch         (chIf[g])
        );
    end

    assign rdAcc[0] = '0;
    wire [DATA_W-1:0] rdMux = rdAcc[NUM_CH]
                            | (selCtrl ? DATA_W'(ctrl_r)   : '0)
                            | (selStat ? DATA_W'(status_r) : '0)
                            | (selMask ? DATA_W'(mask_r)   : '0);

    // Lock only ever sets; clearing it takes a reset
    wire [CTRL_W-1:0] ctrlWr = ctrlMerged[CTRL_W-1:0];
    assign ctrl_nxt = (wrEn & selCtrl)
                    ? (ctrlWr | (CTRL_W'(locked) << CTRL_LOCK_BIT))
                    : ctrl_r;
    assign mask_nxt = (wrEn & selMask) ? maskMerged[NUM_EV-1:0] : mask_r;

    // Events: channel overtemp entry, and the pin pulled low from outside
    wire              drivingAny = |(otActive & driveEn);
    wire [NUM_CH-1:0] otRise     = otActive & ~otPrev_r;
    wire              pinFall    = pinFunc & ~pinOe_r & pinPrev_r & ~overtempPinIn;
    wire [NUM_EV-1:0] events     = {pinFall, otRise};
    wire [NUM_EV-1:0] w1c        = (wrEn & selStat) ? w1cWord[NUM_EV-1:0] : '0;
    // Set beats clear so an event in the clearing cycle survives
    assign status_nxt = (status_r & ~w1c) | events;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                spanCfg_r[i] <= SPAN_RESET;
                lim_r[i]     <= LIM_RESET;
            end
        end else begin
            spanCfg_r <= spanCfg_nxt;
            lim_r     <= lim_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= CTRL_RESET;
            status_r <= '0;
            mask_r   <= '0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
        end
    end

    // Read data is captured in setup so it is stable through the access phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (setupRd) begin
            prdata_r <= rdMux;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otPrev_r  <= '0;
            pinPrev_r <= 1'b1;
            pinOe_r   <= 1'b0;
        end else begin
            otPrev_r  <= otActive;
            pinPrev_r <= overtempPinIn;
            // Channels without drive enable never pull the pin
            pinOe_r   <= pinFunc & drivingAny;
        end
    end

    assign prdata         = prdata_r;
    assign pready         = 1'b1;
    assign pslverr        = access & ~hit;
    assign overtempPinOut = 1'b0;
    assign overtempPinOe  = pinOe_r;
    assign pwmOut1        = pwmRaw[0];
    assign pwmOut2        = pwmRaw[1];
    assign pwmOut3        = pwmRaw[2];
    assign irq            = |(status_r & mask_r);
endmodule
`default_nettype wire

// ---- test/fpsc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpsc_chk #(
    parameter longint CLK_HZ       = fpsc_pkg::CLK_HZ_DEF,
    parameter longint MON_CYCLE_US = fpsc_pkg::MON_CYCLE_US_DEF
) (
    input wire logic                          clk,
    input wire logic                          rst,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [fpsc_pkg::ADDR_W-1:0]   paddr,
    input wire logic [fpsc_pkg::DATA_W-1:0]   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    input wire logic [fpsc_pkg::TEMP_W-1:0]   tempRemote1,
    input wire logic [fpsc_pkg::TEMP_W-1:0]   tempLocal,
    input wire logic [fpsc_pkg::TEMP_W-1:0]   tempRemote2,
    input wire logic                          overtempPinOut,
    input wire logic                          overtempPinOe
);
    import fpsc_pkg::*;
    localparam int MONC = int'(CLK_HZ * MON_CYCLE_US / US_PER_S);
    // Limits are taken at their reset value; the bench never rewrites them
    localparam logic [TEMP_W-1:0] OT_Q = TEMP_W'(LIM_RESET[15:8]) << TEMP_FRAC;
    logic        hot;
    logic        spanHit;
    logic        mapped;
    logic [15:0] oeCnt_r;
    assign hot = tempRemote1 > OT_Q || tempLocal > OT_Q || tempRemote2 > OT_Q;
    assign spanHit = paddr[ADDR_W-1:2] inside {IDX_REMOTE1, IDX_LOCAL, IDX_REMOTE2}
                     && paddr[1:0] == 2'b00;
    assign mapped = spanHit || paddr inside {ADDR_LIM_BASE, ADDR_LIM_BASE + 12'h004,
                    ADDR_LIM_BASE + 12'h008, ADDR_CTRL, ADDR_STATUS, ADDR_MASK};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oeCnt_r <= '0;
        end else begin
            oeCnt_r <= overtempPinOe ? oeCnt_r + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_span_access;
        s_access ##0 spanHit;
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_pin_low: assert property (overtempPinOut == 1'b0)
        else $error("pin driven high");
    a_span_no_err: assert property (s_span_access |-> !pslverr)
        else $error("span access gave error");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    a_unmapped_err: assert property (s_access ##0 (!mapped && !pwrite) |-> pslverr && prdata == '0)
        else $error("unmapped read not refused");
    a_ot_rise_hot: assert property ($rose(overtempPinOe) |-> $past(hot, 2))
        else $error("pin asserted while cool");
    a_ot_fall_cool: assert property ($fell(overtempPinOe) |-> !$past(hot, 2))
        else $error("pin released while hot");
    a_ot_min_hold: assert property ($fell(overtempPinOe) |-> oeCnt_r >= MONC - 1)
        else $error("pin assertion too short");
endmodule
bind fpsc_top fpsc_chk #(.CLK_HZ(CLK_HZ), .MON_CYCLE_US(MON_CYCLE_US)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tempRemote1(tempRemote1), .tempLocal(tempLocal), .tempRemote2(tempRemote2),
    .overtempPinOut(overtempPinOut), .overtempPinOe(overtempPinOe));
`default_nettype wire

// ---- test/fpsc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpsc_pin_model (
    input wire logic  overtempPinOut,
    input wire logic  overtempPinOe,
    input wire logic  extPullLow,
    output logic      pinLevel
);
    // Board net with a pull-up: any party sinking it wins, released it reads high
    assign pinLevel = ((overtempPinOe && !overtempPinOut) || extPullLow) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fpsc_pkg::*;
    localparam longint TB_CLK_HZ = 25_600;
    localparam longint TB_MON_US = 1_000;
    localparam int     MONC      = int'(TB_CLK_HZ * TB_MON_US / US_PER_S);
    logic              clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rdat;
    logic [STRB_W-1:0] pstrb;
    logic [TEMP_W-1:0] t1, t2, t3;
    logic              pinIn, pinOut, pinOe, extPull, pwm1, pwm2, pwm3, rerr;
    int                num_errors, tests_run, n, bad;
    longint            s;

    fpsc_top #(.CLK_HZ(TB_CLK_HZ), .MON_CYCLE_US(TB_MON_US)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tempRemote1(t1), .tempLocal(t2),
        .tempRemote2(t3), .overtempPinIn(pinIn), .overtempPinOut(pinOut),
        .overtempPinOe(pinOe), .pwmOut1(pwm1), .pwmOut2(pwm2), .pwmOut3(pwm3), .irq(irq));
    fpsc_pin_model pin_u (.overtempPinOut(pinOut), .overtempPinOe(pinOe),
        .extPullLow(extPull), .pinLevel(pinIn));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chkWord(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chkBit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    // Zero-wait slave, but the master still waits on pready as the bus demands
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= 4'hF;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        apb(1'b0, a, '0);
        chkWord(what, e, rdat);
    endtask
    function automatic logic [ADDR_W-1:0] spanA(input int ch);
        return ADDR_W'({SPAN_IDX[ch], 2'b00});
    endfunction
    task automatic waitOe(input logic v, input int lim);
        for (int i = 0; i < lim && pinOe !== v; i++) @(negedge clk);
    endtask
    task automatic riseTime(output time t);
        wait (pwm1 === 1'b0);
        @(posedge pwm1);
        t = $time;
    endtask
    task automatic steady(input string what, input logic v);
        bad = 0;
        repeat (300) begin
            @(negedge clk);
            if (pwm1 !== v) bad++;
        end
        chkWord(what, '0, 32'(bad));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        num_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        conclude();
    end

    initial begin
        time ta, tb;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        pstrb = '0; t1 = 10'd200; t2 = 10'd200; t3 = 10'd200; extPull = 1'b0;
        num_errors = 0; tests_run = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) rd("span reset", spanA(c), 32'h0000_00C4);
        $display("test reset values done");
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, spanA(k % 3), 32'({4'(k), 1'b0, 3'(k)}));
            rd("span field", spanA(k % 3), 32'({4'(k), 1'b0, 3'(k)}));
        end
        $display("test field codes done");
        t1 <= 10'd320;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, spanA(0), 32'({4'hC, 1'b0, 3'(c)}));
            riseTime(ta);
            riseTime(ta);
            riseTime(tb);
            s = TB_CLK_HZ * CHZ_PER_HZ / (RATE_CHZ[c] * PWM_STEPS);
            if (s < 1) s = 1;
            chkWord("pwm period", 32'(PWM_STEPS * s), 32'((tb - ta) / 40));
        end
        $display("test pwm rates done");
        // Narrowest span at the fastest rate: one degree above start is half of full duty
        apb(1'b1, spanA(0), 32'h0000_0007);
        t1 <= 10'd244;
        repeat (8) @(posedge clk);
        bad = 0;
        repeat (256) begin
            @(negedge clk);
            if (pwm1 === 1'b1) bad++;
        end
        chkWord("duty at half span", 32'h0000_007F, 32'(bad));
        $display("test duty slope done");
        @(posedge clk);
        t1 <= 10'd396;
        repeat (600) @(posedge clk);
        steady("full duty high", 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0000_0006);
        repeat (600) @(posedge clk);
        steady("full duty flipped low", 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0000_0002);
        $display("test polarity done");
        apb(1'b1, ADDR_MASK, 32'h0000_0001);
        apb(1'b1, spanA(0), 32'h0000_00CC);
        t1 <= 10'd401;
        waitOe(1'b1, 10);
        chkBit("pin driven", 1'b1, pinOe);
        chkBit("pin level", 1'b0, pinIn);
        @(posedge clk);
        t1 <= 10'd400;
        repeat (10) @(negedge clk);
        chkBit("pin min hold", 1'b1, pinOe);
        rd("status event", ADDR_STATUS, 32'h0000_0001);
        chkBit("irq raised", 1'b1, irq);
        apb(1'b1, ADDR_STATUS, 32'h0000_0001);
        rd("status cleared", ADDR_STATUS, 32'h0000_0000);
        chkBit("irq cleared", 1'b0, irq);
        waitOe(1'b0, MONC + 10);
        chkBit("pin released", 1'b0, pinOe);
        @(posedge clk);
        t1 <= 10'd401;
        waitOe(1'b1, 10);
        repeat (3 * MONC) @(negedge clk);
        chkBit("pin held while hot", 1'b1, pinOe);
        @(posedge clk);
        t1 <= 10'd400;
        waitOe(1'b0, MONC + 10);
        chkBit("pin released at limit", 1'b0, pinOe);
        $display("test overtemp drive done");
        apb(1'b1, spanA(0), 32'h0000_00C4);
        apb(1'b1, ADDR_STATUS, 32'h0000_000F);
        apb(1'b1, ADDR_MASK, 32'h0000_0008);
        t1 <= 10'd401;
        bad = 0;
        repeat (3 * MONC) begin
            @(negedge clk);
            if (pinOe !== 1'b0) bad++;
        end
        chkWord("pin not driven", '0, 32'(bad));
        @(posedge clk);
        extPull <= 1'b1;
        repeat (5) @(posedge clk);
        extPull <= 1'b0;
        apb(1'b0, ADDR_STATUS, '0);
        chkBit("external pull seen", 1'b1, rdat[EV_PIN_BIT]);
        chkBit("irq masked event", 1'b1, irq);
        apb(1'b1, ADDR_MASK, 32'h0000_0000);
        // The mask lands on the edge the write task returns at; look once it has settled
        @(negedge clk);
        chkBit("irq masked off", 1'b0, irq);
        t1 <= 10'd200;
        $display("test pin input done");
        apb(1'b0, 12'h1FC, 32'h0000_0000);
        chkBit("unmapped err", 1'b1, rerr);
        chkWord("unmapped data", '0, rdat);
        $display("test unmapped done");
        apb(1'b1, spanA(1), 32'h0000_005A);
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        apb(1'b1, spanA(1), 32'h0000_0000);
        chkBit("locked write err", 1'b0, rerr);
        rd("locked span", spanA(1), 32'h0000_005A);
        $display("test lock done");
        conclude();
    end
endmodule
`default_nettype wire
